// ==== core/bprep_pkg.sv ====
package bprep_pkg;
  // Clock rate and cycle derivation.
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
  // Reporting period limits in milliseconds.
  localparam int unsigned PERIOD_MIN_MS = 50;
  localparam int unsigned PERIOD_MAX_MS = 600;
  localparam int unsigned PERIOD_DEF_MS = 100;
  // Minimum time above the receive threshold before detection, in microseconds.
  localparam int unsigned MIN_DETECT_US = 500;
  localparam int unsigned US_PER_MS = 1000;
  localparam int unsigned MIN_DETECT_CYC = (MIN_DETECT_US * CYC_PER_MS + US_PER_MS - 1) / US_PER_MS;
  // Millisecond tick divider width.
  localparam int unsigned MS_DIV_W = 16;
  localparam logic [15:0] MS_DIV_LAST = 16'(CYC_PER_MS - 1);
  localparam int unsigned PERIOD_W = 10;
  localparam int unsigned DET_W = 16;
  // Telegram and position widths.
  localparam int unsigned TGM_W = 32;
  localparam int unsigned POS_W = 32;
  localparam int unsigned FIFO_DEPTH = 8;
  // Report kinds.
  typedef enum logic [1:0] {
    BPREP_KIND_TGM = 2'h0,
    BPREP_KIND_DET_ONLY = 2'h1,
    BPREP_KIND_PRELIM = 2'h2
  } bprep_kind_t;
endpackage

// ==== core/bprep_fifo.sv ====
`timescale 1ns/10ps
module bprep_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk_sys_i, // System clock.
  input wire logic nrst_i, // Asynchronous reset, active low.
  input wire logic in_valid_i, // Write request.
  output logic in_ready_o, // Space available.
  input wire logic [WIDTH-1:0] in_data_i, // Write data.
  output logic out_valid_o, // Data available.
  input wire logic out_ready_i, // Read accept.
  output logic [WIDTH-1:0] out_data_o // Read data.
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== core/bprep_core.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - After passage, report telegram with reference position.
// - Switched telegrams: forward one with its position.
// - First valid telegram of passage is kept.
// - Detected without telegram gives detection-only report.
// - All-zero or all-one uplink counts as undecoded.
// - Slow passage may forward several telegrams.
// - Unpassed after one period: preliminary report.
// - Repeat preliminary report every period while unpassed.
// - Period configurable between 50 and 600 ms.
// - Preliminary position may come from side lobe.
// - No telegram forwarded while field below threshold.
// - Detect only after threshold held for minimum time.
module bprep_core #(
  parameter int unsigned TGM_W = bprep_pkg::TGM_W,
  parameter int unsigned POS_W = bprep_pkg::POS_W,
  parameter int unsigned DEPTH = bprep_pkg::FIFO_DEPTH,
  parameter int unsigned DET_CYC = bprep_pkg::MIN_DETECT_CYC
) (
  input wire logic clk_sys_i, // System clock, 40 MHz.
  input wire logic nrst_i, // Asynchronous reset, active low.
  input wire logic above_thr_i, // Field above receive_threshold.
  input wire logic tx_start_i, // Pulse: beacon transmission started.
  input wire logic passed_i, // Pulse: beacon passage complete.
  input wire logic tgm_valid_i, // Pulse: decoded telegram valid.
  input wire logic [TGM_W-1:0] tgm_data_i, // Decoded telegram.
  input wire logic [POS_W-1:0] tgm_pos_i, // Reference position of telegram.
  input wire logic uplink_const_i, // Uplink is constant zeros or ones.
  input wire logic [POS_W-1:0] lobe_pos_i, // Preliminary position estimate.
  input wire logic lobe_sel_i, // Use side lobe position in preliminaries.
  input wire logic multi_en_i, // Forward every switched telegram.
  input wire logic [bprep_pkg::PERIOD_W-1:0] period_ms_i, // Reporting period in ms.
  output logic det_o, // Beacon detected.
  output logic rpt_valid_o, // Report available.
  input wire logic rpt_ready_i, // Kernel accepts report.
  output logic [1:0] rpt_kind_o, // Report kind.
  output logic rpt_final_o, // High on passage-complete reports.
  output logic [TGM_W-1:0] rpt_tgm_o, // Telegram data.
  output logic [POS_W-1:0] rpt_pos_o, // Location reference.
  output logic drop_o // Pulse: report lost to a full FIFO.
);
  localparam int unsigned RW = 2 + 1 + TGM_W + POS_W;
  localparam int unsigned DET_W_L = bprep_pkg::DET_W;
  localparam logic [DET_W_L-1:0] DET_LAST = DET_W_L'(DET_CYC - 1);
  localparam int unsigned MS_DIV_W_L = bprep_pkg::MS_DIV_W;

  // ------------------------------------------------------------
  // Passage state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    BPREP_IDLE = 2'h0,
    BPREP_ACTIVE = 2'h1,
    BPREP_FLUSH = 2'h2
  } bprep_state_t;

  bprep_state_t state_q;
  logic [DET_W_L-1:0] det_cnt_q;
  logic det_q;
  logic [MS_DIV_W_L-1:0] div_q;
  logic ms_tick;
  logic [bprep_pkg::PERIOD_W-1:0] per_cnt_q;
  logic [bprep_pkg::PERIOD_W-1:0] period_eff;
  logic have_tgm_q;
  logic [TGM_W-1:0] keep_tgm_q;
  logic [POS_W-1:0] keep_pos_q;
  logic tgm_ok;
  logic prelim_due;
  logic push_valid;
  logic push_ready;
  logic [RW-1:0] push_data;
  logic [RW-1:0] pop_data;
  logic pop_valid;
  logic pop_take;

  // ------------------------------------------------------------
  // Detection filter
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      det_cnt_q <= '0;
      det_q <= 1'b0;
    end else if (!above_thr_i) begin
      det_cnt_q <= '0;
      det_q <= 1'b0;
    end else if (det_cnt_q == DET_LAST) begin
      det_q <= 1'b1;
    end else begin
      det_cnt_q <= det_cnt_q + 1'b1;
    end
  end

  // A telegram counts only above threshold and when not constant.
  assign tgm_ok = tgm_valid_i && above_thr_i && !uplink_const_i;

  // ------------------------------------------------------------
  // Millisecond tick and reporting period
  // ------------------------------------------------------------
  assign ms_tick = (div_q == bprep_pkg::MS_DIV_LAST[MS_DIV_W_L-1:0]);

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_q <= '0;
    end else if (ms_tick || state_q != BPREP_ACTIVE) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // Out-of-range period requests are clamped to the supported span.
  always_comb begin
    if (period_ms_i < bprep_pkg::PERIOD_W'(bprep_pkg::PERIOD_MIN_MS)) begin
      period_eff = bprep_pkg::PERIOD_W'(bprep_pkg::PERIOD_MIN_MS);
    end else if (period_ms_i > bprep_pkg::PERIOD_W'(bprep_pkg::PERIOD_MAX_MS)) begin
      period_eff = bprep_pkg::PERIOD_W'(bprep_pkg::PERIOD_MAX_MS);
    end else begin
      period_eff = period_ms_i;
    end
  end

  assign prelim_due = (state_q == BPREP_ACTIVE) && ms_tick && !passed_i
                      && (per_cnt_q == period_eff - 1'b1);

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      per_cnt_q <= '0;
    end else if (state_q != BPREP_ACTIVE) begin
      per_cnt_q <= '0;
    end else if (prelim_due) begin
      per_cnt_q <= '0;
    end else if (ms_tick) begin
      per_cnt_q <= per_cnt_q + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Passage sequencing and telegram selection
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= BPREP_IDLE;
    end else begin
      unique case (state_q)
        BPREP_IDLE: begin
          if (tx_start_i) begin
            state_q <= BPREP_ACTIVE;
          end
        end
        BPREP_ACTIVE: begin
          if (passed_i) begin
            state_q <= BPREP_FLUSH;
          end
        end
        BPREP_FLUSH: begin
          if (push_ready) begin
            state_q <= BPREP_IDLE;
          end
        end
        default: begin
          state_q <= BPREP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      have_tgm_q <= 1'b0;
      keep_tgm_q <= '0;
      keep_pos_q <= '0;
    end else if (state_q == BPREP_IDLE) begin
      have_tgm_q <= 1'b0;
    end else if (state_q == BPREP_ACTIVE && tgm_ok && !have_tgm_q) begin
      have_tgm_q <= 1'b1;
      keep_tgm_q <= tgm_data_i;
      keep_pos_q <= tgm_pos_i;
    end
  end

  // ------------------------------------------------------------
  // Report assembly
  // ------------------------------------------------------------
  always_comb begin
    push_valid = 1'b0;
    push_data = {2'(bprep_pkg::BPREP_KIND_TGM), 1'b1, keep_tgm_q, keep_pos_q};
    if (state_q == BPREP_FLUSH) begin
      push_valid = have_tgm_q || det_q || tgm_ok;
      if (!have_tgm_q) begin
        push_data = {2'(bprep_pkg::BPREP_KIND_DET_ONLY), 1'b1, {TGM_W{1'b0}}, lobe_pos_i};
      end
    end else if (state_q == BPREP_ACTIVE && multi_en_i && tgm_ok && have_tgm_q) begin
      push_valid = 1'b1;
      push_data = {2'(bprep_pkg::BPREP_KIND_TGM), 1'b0, tgm_data_i, tgm_pos_i};
    end else if (prelim_due) begin
      push_valid = 1'b1;
      push_data = {2'(bprep_pkg::BPREP_KIND_PRELIM), 1'b0, keep_tgm_q,
                   lobe_sel_i ? lobe_pos_i : keep_pos_q};
    end
  end

  bprep_fifo #(
    .WIDTH(RW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .in_data_i(push_data),
    .out_valid_o(pop_valid),
    .out_ready_i(pop_take),
    .out_data_o(pop_data)
  );

  // ------------------------------------------------------------
  // Output register stage
  // ------------------------------------------------------------
  assign pop_take = pop_valid && (!rpt_valid_o || rpt_ready_i);

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rpt_valid_o <= 1'b0;
      rpt_kind_o <= 2'h0;
      rpt_final_o <= 1'b0;
      rpt_tgm_o <= '0;
      rpt_pos_o <= '0;
    end else if (pop_take) begin
      rpt_valid_o <= 1'b1;
      rpt_kind_o <= pop_data[RW-1 -: 2];
      rpt_final_o <= pop_data[RW-3];
      rpt_tgm_o <= pop_data[POS_W +: TGM_W];
      rpt_pos_o <= pop_data[POS_W-1:0];
    end else if (rpt_ready_i) begin
      rpt_valid_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      det_o <= 1'b0;
      drop_o <= 1'b0;
    end else begin
      det_o <= det_q;
      drop_o <= push_valid && !push_ready && (state_q != BPREP_FLUSH);
    end
  end
endmodule

// ==== bench/bprep_core_props.sv ====
`timescale 1ns/10ps
module bprep_core_props #(
  parameter int unsigned TGM_W = bprep_pkg::TGM_W,
  parameter int unsigned POS_W = bprep_pkg::POS_W,
  parameter int unsigned DET_CYC = bprep_pkg::MIN_DETECT_CYC
) (
  input wire logic clk_sys_i, // System clock.
  input wire logic nrst_i, // Reset, active low.
  input wire logic above_thr_i, // Field above threshold.
  input wire logic tx_start_i, // Transmission start.
  input wire logic multi_en_i, // Multi forwarding.
  input wire logic det_o, // Detected.
  input wire logic rpt_valid_o, // Report valid.
  input wire logic rpt_ready_i, // Report accept.
  input wire logic [1:0] rpt_kind_o, // Report kind.
  input wire logic rpt_final_o, // Final flag.
  input wire logic [TGM_W-1:0] rpt_tgm_o, // Telegram.
  input wire logic [POS_W-1:0] rpt_pos_o // Position.
);
  localparam int unsigned EARLY = (bprep_pkg::PERIOD_MIN_MS - 1) * bprep_pkg::CYC_PER_MS;
  logic [15:0] run_q;
  logic [31:0] since_q;
  // Counts consecutive cycles with the field above threshold.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_q <= 16'h0;
    end else if (!above_thr_i) begin
      run_q <= 16'h0;
    end else if (run_q != 16'hFFFF) begin
      run_q <= run_q + 16'h1;
    end
  end
  // Counts cycles since the last transmission start.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      since_q <= 32'h0;
    end else if (tx_start_i) begin
      since_q <= 32'h0;
    end else if (since_q != 32'hFFFFFFFF) begin
      since_q <= since_q + 32'h1;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  sequence stall_s;
    rpt_valid_o && !rpt_ready_i;
  endsequence
  sequence held_s;
    $stable(rpt_tgm_o) && $stable(rpt_pos_o) && $stable(rpt_kind_o) && $stable(rpt_final_o);
  endsequence
  hold_valid_a: assert property (stall_s |=> rpt_valid_o)
    else $error("report withdrawn before accept");
  hold_data_a: assert property (stall_s |=> held_s)
    else $error("report changed before accept");
  kind_legal_a: assert property (rpt_valid_o |-> rpt_kind_o != 2'h3)
    else $error("illegal report kind");
  prelim_final_a: assert property (rpt_valid_o && rpt_kind_o == bprep_pkg::BPREP_KIND_PRELIM
    |-> !rpt_final_o)
    else $error("preliminary report flagged final");
  detonly_final_a: assert property (rpt_valid_o && rpt_kind_o == bprep_pkg::BPREP_KIND_DET_ONLY
    |-> rpt_final_o)
    else $error("detection report not final");
  single_tgm_a: assert property (rpt_valid_o && rpt_kind_o == bprep_pkg::BPREP_KIND_TGM
    && !multi_en_i |-> rpt_final_o)
    else $error("extra telegram forwarded");
  det_hold_a: assert property ($rose(det_o) |-> run_q >= DET_CYC - 1)
    else $error("detection before minimum time");
  prelim_early_a: assert property (rpt_valid_o && rpt_kind_o == bprep_pkg::BPREP_KIND_PRELIM
    |-> since_q >= EARLY)
    else $error("preliminary report too early");
endmodule
bind bprep_core bprep_core_props #(.TGM_W(TGM_W), .POS_W(POS_W), .DET_CYC(DET_CYC)) chk_u (
  .clk_sys_i, .nrst_i, .above_thr_i, .tx_start_i, .multi_en_i, .det_o, .rpt_valid_o,
  .rpt_ready_i, .rpt_kind_o, .rpt_final_o, .rpt_tgm_o, .rpt_pos_o);

// ==== bench/bprep_kernel.sv ====
`timescale 1ns/10ps
module bprep_kernel (
  input wire logic clk_sys_i, // System clock.
  input wire logic nrst_i, // Reset, active low.
  input wire logic slow_i, // Stall the report stream.
  output logic rpt_ready_o // Report accept.
);
  logic [1:0] ph_q;
  // Accepts one cycle in four while slow, so reports queue up behind the stall.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph_q <= 2'h0;
      rpt_ready_o <= 1'b0;
    end else begin
      ph_q <= ph_q + 2'h1;
      rpt_ready_o <= !slow_i || ph_q == 2'h0;
    end
  end
endmodule

// ==== bench/balise_passage_reporting_bench.sv ====
`timescale 1ns/10ps
module balise_passage_reporting_bench;
  typedef struct {logic [1:0] kind; logic fin; logic [31:0] tgm; logic [31:0] pos;} bprep_exp_t;
  localparam int unsigned DETC = 4;
  logic clk_sys_i = 1'b0, nrst_i = 1'b0, above_thr_i = 1'b0, tx_start_i = 1'b0;
  logic passed_i = 1'b0, tgm_valid_i = 1'b0, uplink_const_i = 1'b0, lobe_sel_i = 1'b0;
  logic multi_en_i = 1'b0, slow = 1'b0;
  logic [31:0] tgm_data_i = 32'h0, tgm_pos_i = 32'h0, lobe_pos_i = 32'h0, seed = 32'h16;
  logic [9:0] period_ms_i = 10'h032;
  logic det_o, rpt_valid_o, rpt_ready_i, rpt_final_o, drop_o;
  logic [1:0] rpt_kind_o;
  logic [31:0] rpt_tgm_o, rpt_pos_o;
  int fail_count = 0;
  int n_compared = 0;
  bprep_exp_t exp_q[$];
  bprep_exp_t got;
  always #12.5 clk_sys_i = !clk_sys_i;
  bprep_core #(.DET_CYC(DETC)) dut_u (.clk_sys_i, .nrst_i, .above_thr_i, .tx_start_i,
    .passed_i, .tgm_valid_i, .tgm_data_i, .tgm_pos_i, .uplink_const_i, .lobe_pos_i,
    .lobe_sel_i, .multi_en_i, .period_ms_i, .det_o, .rpt_valid_o, .rpt_ready_i,
    .rpt_kind_o, .rpt_final_o, .rpt_tgm_o, .rpt_pos_o, .drop_o);
  bprep_kernel kern_u (.clk_sys_i, .nrst_i, .slow_i(slow), .rpt_ready_o(rpt_ready_i));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One beacon passage: start, optional telegrams, then passage complete.
  task automatic pass(input int n, input logic cst, input logic thr);
    logic [31:0] t, p, t0, p0;
    lobe_pos_i <= rnd();
    above_thr_i <= thr;
    tx_start_i <= 1'b1;
    @(posedge clk_sys_i);
    tx_start_i <= 1'b0;
    repeat (DETC + 4) @(posedge clk_sys_i);
    cmp("det", 32'(thr), 32'(det_o));
    for (int i = 0; i < n; i++) begin
      t = rnd();
      p = rnd();
      if (i == 0) begin
        t0 = t;
        p0 = p;
      end else if (multi_en_i && thr && !cst) begin
        exp_q.push_back(bprep_exp_t'{2'h0, 1'b0, t, p});
      end
      tgm_data_i <= t;
      tgm_pos_i <= p;
      uplink_const_i <= cst;
      tgm_valid_i <= 1'b1;
      @(posedge clk_sys_i);
      tgm_valid_i <= 1'b0;
      @(posedge clk_sys_i);
    end
    if (thr && n > 0 && !cst) begin
      exp_q.push_back(bprep_exp_t'{2'h0, 1'b1, t0, p0});
    end else if (thr) begin
      exp_q.push_back(bprep_exp_t'{2'h1, 1'b1, 32'h0, lobe_pos_i});
    end
    passed_i <= 1'b1;
    @(posedge clk_sys_i);
    passed_i <= 1'b0;
    above_thr_i <= 1'b0;
    uplink_const_i <= 1'b0;
    repeat (30) @(posedge clk_sys_i);
  endtask
  // Takes the oldest expectation off the queue at every accepted report.
  always @(posedge clk_sys_i) begin
    if (nrst_i === 1'b1 && drop_o !== 1'b0) begin
      cmp("drop", 32'h0, 32'(drop_o));
    end
    if (nrst_i === 1'b1 && rpt_valid_o === 1'b1 && rpt_ready_i === 1'b1) begin
      if (exp_q.size() == 0) begin
        cmp("unexpected report", 32'h0, 32'h1);
      end else begin
        got = exp_q.pop_front();
        cmp("kind", 32'(got.kind), 32'(rpt_kind_o));
        cmp("final", 32'(got.fin), 32'(rpt_final_o));
        cmp("position", got.pos, rpt_pos_o);
        if (got.kind == 2'h0) begin
          cmp("telegram", got.tgm, rpt_tgm_o);
        end
      end
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    pass(1, 1'b0, 1'b1);
    pass(3, 1'b0, 1'b1);
    pass(0, 1'b0, 1'b1);
    pass(2, 1'b1, 1'b1);
    pass(1, 1'b0, 1'b0);
    multi_en_i <= 1'b1;
    pass(3, 1'b0, 1'b1);
    slow <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      lobe_sel_i <= rnd() & 32'h1;
      period_ms_i <= 10'(32'd50 + rnd() % 32'd551);
      pass(int'(rnd() % 32'd4), 1'b0, 1'b1);
    end
    cmp("pending", 32'h0, 32'(exp_q.size()));
    conclude();
  end
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    fail_count++;
    conclude();
  end
endmodule
